// File: design/sensor_frame_control.sv
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module sensor_frame_control
  import sensor_frame_pkg::*;
#(
  parameter int COUNT_W = sensor_frame_pkg::LC_W
) (
  // clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 resetn_i,
  // avalon-mm slave
  input  wire logic [sensor_frame_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                                 avs_read_i,
  input  wire logic                                 avs_write_i,
  input  wire logic [sensor_frame_pkg::DATA_W-1:0]  avs_writedata_i,
  input  wire logic [3:0]                           avs_byteenable_i,
  output logic      [sensor_frame_pkg::DATA_W-1:0]  avs_readdata_o,
  output logic                                      avs_waitrequest_o,
  // sensor pins
  input  wire logic                                 pclk_i,
  input  wire logic                                 hsync_i,
  input  wire logic                                 vsync_i,
  input  wire logic                                 vertical_drive_i,
  input  wire logic                                 field_id_input_i,
  output logic                                      hsync_o,
  output logic                                      vsync_o,
  output logic                                      sync_oe_o,
  // lens shading done event
  input  wire logic                                 lsc_done_i,
  // interrupts
  output logic                                      line_count_irq_a_o,
  output logic                                      line_count_irq_b_o,
  output logic                                      line_count_irq_c_o,
  output logic                                      lens_shading_irq_o,
  // applied settings toward pipe and memory
  output logic                                      frame_active_o,
  output logic                                      sdram_write_enable_o,
  output logic                                      pipe_gain_enable_o,
  output logic                                      stats_gain_enable_o,
  output logic                                      pipe_offset_enable_o,
  output logic                                      stats_offset_enable_o,
  output logic      [sensor_frame_pkg::PTR_W-1:0]   mem_addr_o,
  output logic      [sensor_frame_pkg::PTR_W-1:0]   line_offset_o,
  output logic      [sensor_frame_pkg::LC_W-1:0]    line_length_setting_o
);
  import sensor_frame_pkg::*;

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ***************************************************************
  // pin synchronisers and edge finding
  // ***************************************************************
  logic [PIN_N-1:0] pin_meta;
  logic [PIN_N-1:0] pin_sync;
  logic             pclk_last;
  logic [PIN_N-1:0] px_last;
  logic             pix_en;
  logic [PIN_N-1:0] px_rise;

  // two stages before any logic looks at a pin
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta  <= '0;
      pin_sync  <= '0;
      pclk_last <= 1'b0;
    end else begin
      pin_meta  <= {field_id_input_i, vertical_drive_i, vsync_i, hsync_i, pclk_i};
      pin_sync  <= pin_meta;
      pclk_last <= pin_sync[PIN_PCLK];
    end
  end

  assign pix_en = pin_sync[PIN_PCLK] & ~pclk_last;

  // sync levels are sampled once per pixel clock rising edge
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      px_last <= '0;
    end else if (pix_en) begin
      px_last <= pin_sync;
    end
  end

  assign px_rise = {PIN_N{pix_en}} & pin_sync & ~px_last;

  // ***************************************************************
  // written register state
  // ***************************************************************
  bus_state_type      bus_state;
  logic               wr_fire;
  logic               run_en;
  logic               vpol;
  logic               sync_dir;
  logic               mode_656;
  logic               bypass;
  logic [COUNT_W-1:0] lc_set [3];
  logic [SH_W-1:0]    shctl_w;
  logic [PTR_W-1:0]   mem_addr_w;
  logic [PTR_W-1:0]   line_ofs_w;
  logic [LC_W-1:0]    line_len_w;
  logic [LC_W-1:0]    ppl_w;
  logic [LC_W-1:0]    lpf_w;
  logic [LC_W-1:0]    ppl_a;
  logic [LC_W-1:0]    lpf_a;
  logic               parity;

  // byte-lane merge shared by the line-count and shadowed register writes
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [3:0]        be);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // write lands on the edge where waitrequest is sampled low
  assign wr_fire = (bus_state == BUS_ACK) && avs_write_i;

  // busy-writeable settings take effect at once
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_en   <= 1'b0;
      vpol     <= 1'b0;
      sync_dir <= 1'b0;
      mode_656 <= 1'b0;
      bypass   <= 1'b0;
    end else if (wr_fire && avs_byteenable_i[0]) begin
      case (avs_address_i)
        OFS_CTRL: run_en <= avs_writedata_i[CTRL_RUN];
        OFS_MODE: begin
          vpol     <= avs_writedata_i[MODE_VPOL];
          sync_dir <= avs_writedata_i[MODE_DIR];
          mode_656 <= avs_writedata_i[MODE_656];
        end
        OFS_CFG: bypass <= avs_writedata_i[CFG_BYPASS];
        default: ;
      endcase
    end else if (wr_fire) begin
      run_en <= run_en;
    end
  end

  // line-count settings, busy-writeable and byte addressable
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lc_set <= '{default: '0};
    end else if (wr_fire) begin
      case (avs_address_i)
        OFS_LCA: lc_set[0] <= COUNT_W'(merge(DATA_W'(lc_set[0]), avs_writedata_i,
                                            avs_byteenable_i));
        OFS_LCB: lc_set[1] <= COUNT_W'(merge(DATA_W'(lc_set[1]), avs_writedata_i,
                                            avs_byteenable_i));
        OFS_LCC: lc_set[2] <= COUNT_W'(merge(DATA_W'(lc_set[2]), avs_writedata_i,
                                            avs_byteenable_i));
        default: ;
      endcase
    end
  end

  // shadowed settings hold the last write until the latch event
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shctl_w    <= '0;
      mem_addr_w <= '0;
      line_ofs_w <= '0;
      line_len_w <= '0;
      ppl_w      <= PPL_RESET;
      lpf_w      <= LPF_RESET;
    end else if (wr_fire) begin
      case (avs_address_i)
        OFS_SHCTL:   shctl_w    <= SH_W'(merge(DATA_W'(shctl_w), avs_writedata_i,
                                              avs_byteenable_i));
        OFS_MEMADDR: mem_addr_w <= merge(mem_addr_w, avs_writedata_i, avs_byteenable_i);
        OFS_LINEOFS: line_ofs_w <= merge(line_ofs_w, avs_writedata_i, avs_byteenable_i);
        OFS_LINELEN: line_len_w <= LC_W'(merge(DATA_W'(line_len_w), avs_writedata_i,
                                              avs_byteenable_i));
        OFS_PPL:     ppl_w      <= LC_W'(merge(DATA_W'(ppl_w), avs_writedata_i,
                                              avs_byteenable_i));
        OFS_LPF:     lpf_w      <= LC_W'(merge(DATA_W'(lpf_w), avs_writedata_i,
                                              avs_byteenable_i));
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // bus slave: one wait cycle, unmapped reads return zero
  // ***************************************************************
  logic [DATA_W-1:0] next_readdata;
  frame_state_type   fr_state;

  always_comb begin
    next_readdata = '0;
    case (avs_address_i)
      OFS_CTRL:    next_readdata[CTRL_RUN] = run_en;
      OFS_MODE: begin
        next_readdata[MODE_VPOL]   = vpol;
        next_readdata[MODE_DIR]    = sync_dir;
        next_readdata[MODE_656]    = mode_656;
        next_readdata[MODE_PARITY] = parity;
      end
      OFS_CFG:     next_readdata[CFG_BYPASS] = bypass;
      OFS_LCA:     next_readdata = DATA_W'(lc_set[0]);
      OFS_LCB:     next_readdata = DATA_W'(lc_set[1]);
      OFS_LCC:     next_readdata = DATA_W'(lc_set[2]);
      OFS_SHCTL:   next_readdata = DATA_W'(shctl_w);
      OFS_MEMADDR: next_readdata = mem_addr_w;
      OFS_LINEOFS: next_readdata = line_ofs_w;
      OFS_LINELEN: next_readdata = DATA_W'(line_len_w);
      OFS_PPL:     next_readdata = DATA_W'(ppl_w);
      OFS_LPF:     next_readdata = DATA_W'(lpf_w);
      OFS_STATUS: begin
        next_readdata[ST_ACTIVE] = (fr_state == FR_RUN);
        next_readdata[ST_PARITY] = parity;
        next_readdata[ST_MASTER] = sync_dir;
      end
      default:     next_readdata = '0;
    endcase
  end

  // waitrequest idles high and drops for exactly one cycle per access
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_state         <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_state         <= BUS_ACK;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= next_readdata;
          end
        end
        BUS_ACK: begin
          bus_state         <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_state         <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // ***************************************************************
  // master timing generator and trigger selection
  // ***************************************************************
  logic [LC_W-1:0] hcnt;
  logic [LC_W-1:0] vcnt;
  logic            master_run;
  logic            trig;
  logic            line_ev;

  assign master_run = sync_dir && run_en;

  // counters sit at zero while idle, so a frame opens on the first pixel
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hcnt <= '0;
      vcnt <= '0;
    end else if (!master_run) begin
      hcnt <= '0;
      vcnt <= '0;
    end else if (pix_en) begin
      if (hcnt >= ppl_a - 16'h0001) begin
        hcnt <= '0;
        vcnt <= (vcnt >= lpf_a - 16'h0001) ? '0 : vcnt + 16'h0001;
      end else begin
        hcnt <= hcnt + 16'h0001;
      end
    end
  end

  // reference edge in slave mode: vsync when polarity is 0, vertical drive when 1; master uses the counters
  always_comb begin
    if (sync_dir) begin
      trig    = master_run && pix_en && (hcnt == '0) && (vcnt == '0);
      line_ev = master_run && pix_en && (hcnt == '0);
    end else begin
      trig    = vpol ? px_rise[PIN_VD] : px_rise[PIN_VS];
      line_ev = px_rise[PIN_HS];
    end
  end

  // driven sync and its enable
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hsync_o   <= 1'b0;
      vsync_o   <= 1'b0;
      sync_oe_o <= 1'b0;
    end else begin
      hsync_o   <= master_run && (hcnt < HS_WIDTH);
      vsync_o   <= master_run && (vcnt < VS_WIDTH);
      sync_oe_o <= sync_dir;
    end
  end

  // ***************************************************************
  // frame control
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fr_state <= FR_IDLE;
    end else begin
      case (fr_state)
        FR_IDLE: begin
          if (run_en) begin
            fr_state <= sync_dir ? FR_RUN : FR_WAIT;
          end
        end
        FR_WAIT: begin
          if (!run_en) begin
            fr_state <= FR_IDLE;
          end else if (trig) begin
            fr_state <= FR_RUN;
          end
        end
        FR_RUN: begin
          if (!run_en) begin
            fr_state <= FR_IDLE;
          end
        end
        default: fr_state <= FR_IDLE;
      endcase
    end
  end

  assign frame_active_o = fr_state[2];

  // field parity: embedded sync toggles per field, else the field pin
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      parity <= 1'b0;
    end else if (trig) begin
      parity <= mode_656 ? ~parity : pin_sync[PIN_FID];
    end
  end

  // ***************************************************************
  // shadow latching, at each trigger or straight through on bypass
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sdram_write_enable_o  <= 1'b0;
      pipe_gain_enable_o    <= 1'b0;
      stats_gain_enable_o   <= 1'b0;
      pipe_offset_enable_o  <= 1'b0;
      stats_offset_enable_o <= 1'b0;
      mem_addr_o            <= '0;
      line_offset_o         <= '0;
      line_length_setting_o <= '0;
      ppl_a                 <= PPL_RESET;
      lpf_a                 <= LPF_RESET;
    end else if (bypass || trig) begin
      sdram_write_enable_o  <= shctl_w[SH_DWEN];
      pipe_gain_enable_o    <= shctl_w[SH_PIPE_GAIN];
      stats_gain_enable_o   <= shctl_w[SH_STAT_GAIN];
      pipe_offset_enable_o  <= shctl_w[SH_PIPE_OFS];
      stats_offset_enable_o <= shctl_w[SH_STAT_OFS];
      mem_addr_o            <= mem_addr_w;
      line_offset_o         <= line_ofs_w;
      line_length_setting_o <= line_len_w;
      ppl_a                 <= ppl_w;
      lpf_a                 <= lpf_w;
    end
  end

  // ***************************************************************
  // line-count and lens shading interrupts
  // ***************************************************************
  logic [COUNT_W-1:0] lcount;
  logic [COUNT_W-1:0] lcount_inc;
  logic [2:0]         irq_q;
  logic               irq_ok;

  assign lcount_inc = lcount + COUNT_W'(1);
  assign irq_ok     = run_en && (fr_state == FR_RUN);

  // every trigger restarts the count, per field in embedded mode
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lcount <= '0;
    end else if (trig) begin
      lcount <= '0;
    end else if (line_ev && irq_ok) begin
      lcount <= lcount_inc;
    end
  end

  // zero in a count register keeps that interrupt silent
  for (genvar i = 0; i < 3; i++) begin : g_lc_irq
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        irq_q[i] <= 1'b0;
      end else begin
        irq_q[i] <= irq_ok && line_ev && !trig && (lcount_inc == lc_set[i]);
      end
    end
  end

  assign line_count_irq_a_o = irq_q[0];
  assign line_count_irq_b_o = irq_q[1];
  assign line_count_irq_c_o = irq_q[2];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lens_shading_irq_o <= 1'b0;
    end else begin
      lens_shading_irq_o <= run_en && lsc_done_i;
    end
  end
endmodule // sensor_frame_control

// File: inc/sensor_frame_pkg.sv
package sensor_frame_pkg;
  // ***************************************************************
  // bus and field sizes
  // ***************************************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int LC_W   = 16;
  localparam int PTR_W  = 32;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG     = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_LCA     = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_LCB     = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_LCC     = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_SHCTL   = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_MEMADDR = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_LINEOFS = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_LINELEN = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_PPL     = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_LPF     = 6'h2c;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 6'h30;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CTRL_RUN     = 0;
  localparam int MODE_VPOL    = 0;
  localparam int MODE_DIR     = 1;
  localparam int MODE_656     = 2;
  localparam int MODE_PARITY  = 8;
  localparam int CFG_BYPASS   = 0;
  localparam int SH_DWEN      = 0;
  localparam int SH_PIPE_GAIN = 1;
  localparam int SH_STAT_GAIN = 2;
  localparam int SH_PIPE_OFS  = 3;
  localparam int SH_STAT_OFS  = 4;
  localparam int SH_W         = 5;
  localparam int ST_ACTIVE    = 0;
  localparam int ST_PARITY    = 1;
  localparam int ST_MASTER    = 2;

  // ***************************************************************
  // pin indices, reset values, master sync widths
  // ***************************************************************
  localparam int PIN_PCLK  = 0;
  localparam int PIN_HS    = 1;
  localparam int PIN_VS    = 2;
  localparam int PIN_VD    = 3;
  localparam int PIN_FID   = 4;
  localparam int PIN_N     = 5;
  localparam logic [LC_W-1:0] PPL_RESET = 16'h0320;
  localparam logic [LC_W-1:0] LPF_RESET = 16'h020d;
  localparam logic [LC_W-1:0] HS_WIDTH  = 16'h0004;
  localparam logic [LC_W-1:0] VS_WIDTH  = 16'h0001;

  // ***************************************************************
  // state types
  // ***************************************************************
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_type;
  typedef enum logic [2:0] {
    FR_IDLE = 3'b001,
    FR_WAIT = 3'b010,
    FR_RUN  = 3'b100
  } frame_state_type;
endpackage

// File: tb/sensor_frame_monitor.sv
`timescale 1ns/1ps
module sensor_frame_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // sync pins and events
  input wire logic hsync_o,
  input wire logic vsync_o,
  input wire logic sync_oe_o,
  input wire logic lsc_done_i,
  input wire logic frame_active_o,
  // interrupts
  input wire logic line_count_irq_a_o,
  input wire logic line_count_irq_b_o,
  input wire logic line_count_irq_c_o,
  input wire logic lens_shading_irq_o
);
  // one clock domain, so one default for all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_ack_req: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
  a_irq_a_pulse: assert property (line_count_irq_a_o |=> !line_count_irq_a_o)
    else $error("irq a longer than one cycle");
  a_irq_b_pulse: assert property ($rose(line_count_irq_b_o) |=> $fell(line_count_irq_b_o))
    else $error("irq b longer than one cycle");
  a_irq_c_pulse: assert property (line_count_irq_c_o |=> !line_count_irq_c_o)
    else $error("irq c longer than one cycle");
  a_lsc_follows: assert property (lens_shading_irq_o |-> $past(lsc_done_i))
    else $error("shading irq without done event");
  a_irq_active: assert property (line_count_irq_a_o |-> $past(frame_active_o))
    else $error("line irq outside active frame");
  a_slave_quiet: assert property (!sync_oe_o |-> !hsync_o && !vsync_o)
    else $error("sync outputs driven in slave mode");
  a_stop_quiet: assert property ($fell(frame_active_o) |-> ##[0:1] (!hsync_o && !vsync_o))
    else $error("sync outputs still high after stop");
endmodule // sensor_frame_monitor

bind sensor_frame_control sensor_frame_monitor mon_i (.clk_i, .resetn_i, .avs_read_i,
  .avs_write_i, .avs_waitrequest_o, .hsync_o, .vsync_o, .sync_oe_o, .lsc_done_i,
  .frame_active_o, .line_count_irq_a_o, .line_count_irq_b_o, .line_count_irq_c_o,
  .lens_shading_irq_o);

// File: tb/sensor_model.sv
`timescale 1ns/1ps
module sensor_model (
  // system clock paces the pixel clock
  input  wire logic clk_i,
  // sensor pins
  output logic      pclk_o,
  output logic      hsync_o,
  output logic      vsync_o,
  output logic      vdrive_o,
  output logic      fid_o
);
  // current line, 255 outside frames
  int line = 255;
  // pins idle low, pixel clock still between frames
  initial begin
    {pclk_o, hsync_o, vsync_o, vdrive_o, fid_o} = '0;
  end
  // one pixel of 160 ns, pins stable across the pclk rise
  task automatic pix(input logic h, input logic v, input logic d);
    hsync_o <= h;
    vsync_o <= v;
    vdrive_o <= d;
    repeat (4) @(posedge clk_i);
    pclk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    pclk_o <= 1'b0;
  endtask
  // vsync on line 0, vertical drive on line 2, hsync at each line start
  task automatic frame(input int n, input logic f);
    @(posedge clk_i);
    fid_o <= f;
    for (int l = 0; l < n; l++) begin
      line = l;
      for (int p = 0; p < 4; p++) pix(p == 0, l == 0, l == 2);
    end
    pix(1'b0, 1'b0, 1'b0);
    line = 255;
  endtask
  // free pixel clock for master mode
  task automatic clocks(input int n);
    @(posedge clk_i);
    repeat (n) pix(1'b0, 1'b0, 1'b0);
  endtask
endmodule // sensor_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sensor_frame_pkg::*;
  // ********************
  // bench signals
  // ********************
  logic clk_i = 0, resetn_i = 0, rd = 0, wr = 0, lsc = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wdat = '0, rdat, a1, a2;
  logic [PTR_W-1:0] maddr, lofs;
  logic [LC_W-1:0] llen;
  logic waitr, ia, ib, ic, il, act, dwen, pg, sg, po, so, hso, vso, oe;
  logic pclk, hs, vs, vdr, field_id_input;
  logic [3:0] be = 4'hf, lanes = 4'hf;
  int fails = 0, checks = 0, seed = 89;
  logic [31:0] rq[$], iq[$];
  // ********************
  // design and far side
  // ********************
  sensor_frame_control sensor_frame_control_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(waitr),
    .pclk_i(pclk), .hsync_i(hs), .vsync_i(vs), .vertical_drive_i(vdr),
    .field_id_input_i(field_id_input), .hsync_o(hso), .vsync_o(vso), .sync_oe_o(oe),
    .lsc_done_i(lsc), .line_count_irq_a_o(ia), .line_count_irq_b_o(ib),
    .line_count_irq_c_o(ic), .lens_shading_irq_o(il), .frame_active_o(act),
    .sdram_write_enable_o(dwen), .pipe_gain_enable_o(pg), .stats_gain_enable_o(sg),
    .pipe_offset_enable_o(po), .stats_offset_enable_o(so), .mem_addr_o(maddr),
    .line_offset_o(lofs), .line_length_setting_o(llen));
  sensor_model sensor_model_i (.clk_i(clk_i), .pclk_o(pclk), .hsync_o(hs),
    .vsync_o(vs), .vdrive_o(vdr), .fid_o(field_id_input));
  // clock of 20 ns
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n = 0;
    @(posedge clk_i);
    adr <= a; wdat <= d; wr <= w; rd <= !w;
    be <= lanes;
    do @(posedge clk_i); while (waitr !== 1'b0 && ++n < 100);
    rd <= 1'b0; wr <= 1'b0;
    if (n >= 100) fails++;
  endtask
  task automatic bw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic br(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rq.push_back(e);
    bus(1'b0, a, '0);
  endtask
  task automatic step();
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse();
    @(posedge clk_i) lsc <= 1'b1;
    @(posedge clk_i) lsc <= 1'b0;
  endtask
  task automatic pop_irq(input logic [7:0] id);
    chk({id, 8'(sensor_model_i.line)}, iq.size() ? iq.pop_front() : '1);
  endtask
  task automatic end_sim();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchers take the oldest note as each result shows
  always @(posedge clk_i) begin
    if (rd && waitr === 1'b0) chk(rdat, rq.size() ? rq.pop_front() : '1);
    if (ia === 1'b1) pop_irq(8'h00);
    if (ib === 1'b1) pop_irq(8'h01);
    if (ic === 1'b1) pop_irq(8'h02);
    if (il === 1'b1) pop_irq(8'h03);
  end
  // hang guard at 20000 cycles, far beyond the roughly 1300 cycles used
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  // ********************
  // scenarios
  // ********************
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    br(OFS_PPL, 32'(PPL_RESET));
    br(OFS_LPF, 32'(LPF_RESET));
    br(OFS_CTRL, 32'h0);
    bw(6'h3c, 32'hffff_ffff);
    br(6'h3c, 32'h0);
    a1 = $random(seed) & 32'hffff_ffe0;
    a2 = $random(seed) & 32'hffff_ffe0;
    bw(OFS_MEMADDR, a1);
    br(OFS_MEMADDR, a1);
    chk(maddr, 32'h0);
    bw(OFS_CFG, 32'h1);
    step();
    chk(maddr, a1);
    lanes = 4'h3;
    bw(OFS_LINEOFS, 32'hffff_ffe0);
    lanes = 4'hf;
    br(OFS_LINEOFS, 32'h0000_ffe0);
    step();
    chk(lofs, 32'h0000_ffe0);
    for (int k = 0; k < 5; k++) begin
      bw(OFS_SHCTL, 32'h1 << k);
      step();
      chk({so, po, sg, pg, dwen}, 32'h1 << k);
    end
    bw(OFS_SHCTL, 32'h0);
    bw(OFS_CFG, 32'h0);
    bw(OFS_MEMADDR, a2);
    bw(OFS_LINELEN, 32'h21);
    step();
    chk(maddr, a1);
    $display("test registers done");
    bw(OFS_LCA, 32'h1);
    bw(OFS_LCB, 32'h3);
    bw(OFS_LCC, 32'h0);
    bw(OFS_CTRL, 32'h1);
    step();
    chk(act, 32'h0);
    iq.push_back(32'h0001);
    iq.push_back(32'h0103);
    sensor_model_i.frame(5, 1'b1);
    chk(maddr, a2);
    chk(act, 32'h1);
    chk(llen, 32'h21);
    br(OFS_STATUS, 32'h3);
    br(OFS_MODE, 32'h100);
    bw(OFS_MODE, 32'h1);
    bw(OFS_LCA, 32'h2);
    bw(OFS_LCB, 32'h0);
    iq.push_back(32'h0004);
    sensor_model_i.frame(6, 1'b0);
    br(OFS_STATUS, 32'h1);
    $display("test slave triggers done");
    bw(OFS_MODE, 32'h4);
    bw(OFS_LCA, 32'h1);
    iq.push_back(32'h0001);
    iq.push_back(32'h0001);
    sensor_model_i.frame(3, 1'b0);
    br(OFS_STATUS, 32'h3);
    sensor_model_i.frame(3, 1'b0);
    iq.push_back(32'h03ff);
    pulse();
    bw(OFS_LCA, 32'h4);
    fork
      sensor_model_i.frame(6, 1'b0);
      begin
        repeat (70) @(posedge clk_i);
        bw(OFS_CTRL, 32'h0);
      end
    join
    chk(act, 32'h0);
    pulse();
    step();
    $display("test abort done");
    bw(OFS_CFG, 32'h1);
    bw(OFS_PPL, 32'h8);
    bw(OFS_LPF, 32'h6);
    bw(OFS_LCA, 32'h2);
    bw(OFS_MODE, 32'h2);
    bw(OFS_CTRL, 32'h1);
    @(posedge clk_i);
    #1;
    chk({act, oe}, 32'h3);
    iq.push_back(32'h00ff);
    sensor_model_i.clocks(40);
    bw(OFS_CTRL, 32'h0);
    step();
    chk({act, hso, vso}, 32'h0);
    chk(32'(iq.size()), 32'h0);
    $display("test master done");
    end_sim();
  end
endmodule // testbench
